/* File: hw/scsb_pkg.sv */
/*
 * Shared constants for the system clock select and boot block: register
 * indices, field positions, clock mode codes and boot delay counts.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package scsb_pkg;
   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CLKMD = 6'h03;
   localparam logic [5:0] IDX_XOSC = 6'h0a;
   localparam logic [5:0] IDX_TRIM = 6'h0b;
   localparam logic [5:0] IDX_STAT = 6'h0c;
   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int HRC_EN_BIT = 4;
   localparam int LRC_EN_BIT = 2;
   localparam int XO_EN_BIT = 7;
   localparam int XO_DRV_HI = 6;
   localparam int XO_DRV_LO = 5;
   // Crystal drive codes.
   localparam logic [1:0] XO_DRV_LOW = 2'h1;
   localparam logic [1:0] XO_DRV_MID = 2'h2;
   localparam logic [1:0] XO_DRV_HIGH = 2'h3;
   // ----------------------------------------------------------------
   // Clock mode codes.
   // ----------------------------------------------------------------
   localparam logic [7:0] MD_HRC_DIV2 = 8'h34;
   localparam logic [7:0] MD_HRC_DIV4 = 8'h14;
   localparam logic [7:0] MD_HRC_DIV8 = 8'h3c;
   localparam logic [7:0] MD_HRC_DIV16 = 8'h1c;
   localparam logic [7:0] MD_HRC_DIV32 = 8'h7c;
   localparam logic [7:0] MD_HRC_DIV64 = 8'h74;
   localparam logic [7:0] MD_LRC = 8'he4;
   localparam logic [7:0] MD_RESET = 8'he4;
   // Clock sources.
   localparam logic [1:0] SRC_HRC = 2'h0;
   localparam logic [1:0] SRC_LRC = 2'h1;
   localparam logic [1:0] SRC_XO = 2'h2;
   // Boot-time calibration option straps.
   localparam logic [2:0] CAL_OFF = 3'h0;
   localparam logic [2:0] CAL_DIV2 = 3'h1;
   localparam logic [2:0] CAL_DIV4 = 3'h2;
   localparam logic [2:0] CAL_DIV8 = 3'h3;
   localparam logic [2:0] CAL_DIV16 = 3'h4;
   localparam logic [2:0] CAL_DIV32 = 3'h5;
   localparam logic [2:0] CAL_LRC = 3'h6;
   // ----------------------------------------------------------------
   // Boot delays in low RC cycles, and program addresses.
   // ----------------------------------------------------------------
   localparam logic [11:0] BOOT_FAST_CYC = 12'd45;
   localparam logic [11:0] BOOT_NORM_CYC = 12'd3000;
   localparam logic [10:0] RESET_ADDR = 11'h001;
   localparam logic [10:0] IRQ_ADDR = 11'h010;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   typedef enum logic [0:0] {ST_BOOT, ST_RUN} scsb_state_e;
endpackage : scsb_pkg

/* File: hw/scsb_top.sv */
/*
 * Clock source selection, oscillator enables, trim and power-on boot
 * sequencing, with an AHB-Lite register slave.
 * Assumes oscillator levels arrive synchronous to hclk and well below
 * half its rate; boot straps are stable around reset release.
 */
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps

// How it works
// - Crystal, high RC and low RC each have their own enable bit.
// - Software picks the system clock source and divider through the mode register.
// - Mode 34h gives high RC divided by 2; 14h gives divide by 4.
// - Mode 3Ch divides high RC by 8, 1Ch by 16, 7Ch by 32.
// - Mode E4h runs the system clock straight from the low RC.
// - A trim register tunes the high RC, nominally to 16 MHz.
// - Boot holds reset for 45 or 3000 low RC cycles, by strap.
// - Execution starts at 0x001; interrupt entry sits at 0x010; 0x000 reserved.
// - Booting with the low RC option leaves the high RC disabled.
// - Any calibrated boot option disables watchdog and enables low RC.
// - Uncalibrated boot sets mode to low RC, or high RC/64 on fast boot; watchdog on.
// - A mode write switches while sys_clk is low; software keeps the old source enabled.
// - Crystal drive field 01 low, 10 middle, 11 high.
module scsb_top (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator levels and boot straps.
   input wire logic high_rc_osc,
   input wire logic low_rc_osc,
   input wire logic external_crystal_osc,
   input wire logic boot_fast,
   input wire logic [2:0] cal_option,
   // Oscillator control.
   output logic high_rc_osc_en,
   output logic low_rc_osc_en,
   output logic external_crystal_osc_en,
   output logic [1:0] external_crystal_osc_drive,
   output logic [7:0] high_rc_osc_trim,
   // Core side.
   output logic sys_clk,
   output logic core_reset_n,
   output logic [10:0] reset_vector,
   output logic [10:0] irq_vector,
   output logic watchdog_en
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] clkmd;
      logic [7:0] xosc;
      logic [7:0] trim;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      scsb_pkg::scsb_state_e state;
      logic straps_taken;
      logic fast;
      logic [2:0] cal;
      logic [11:0] cnt;
      logic core_rst_n;
      logic wdt_en;
      logic [10:0] rst_vec;
      logic [10:0] irq_vec;
      logic [2:0] osc_prev;
      logic [1:0] act_src;
      logic [2:0] act_k;
      logic [5:0] div_cnt;
      logic sysclk;
   } scsb_state_s;

   scsb_state_s st_q;
   scsb_state_s st_d;

   // Decodes a mode value into {source, log2 divider}; used for the
   // requested selection that act_src and act_k are switched to.
   function automatic logic [4:0] mode_decode(input logic [7:0] md);
      logic [3:0] key;
      logic [4:0] res;
      key = {md[7:5], md[3]};
      res = {scsb_pkg::SRC_LRC, 3'h0};
      case (key)
         4'h2: res = {scsb_pkg::SRC_HRC, 3'h1};
         4'h0: res = {scsb_pkg::SRC_HRC, 3'h2};
         4'h3: res = {scsb_pkg::SRC_HRC, 3'h3};
         4'h1: res = {scsb_pkg::SRC_HRC, 3'h4};
         4'h7: res = {scsb_pkg::SRC_HRC, 3'h5};
         4'h6: res = {scsb_pkg::SRC_HRC, 3'h6};
         4'ha, 4'hb: res = {scsb_pkg::SRC_XO, 3'h0};
         default: res = {scsb_pkg::SRC_LRC, 3'h0};
      endcase
      return res;
   endfunction : mode_decode

   // Picks one oscillator level by source code.
   function automatic logic osc_pick(input logic [2:0] lv, input logic [1:0] src);
      logic r;
      r = lv[0];
      case (src)
         scsb_pkg::SRC_LRC: r = lv[1];
         scsb_pkg::SRC_XO: r = lv[2];
         default: r = lv[0];
      endcase
      return r;
   endfunction : osc_pick

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Bus writes land first so that a read in the following address
   // phase already sees the new value.
   always_comb begin
      logic [2:0] lv;
      logic [2:0] rise;
      logic [4:0] want;
      logic [11:0] target;
      logic addr_ok;
      logic [5:0] idx;
      st_d = st_q;
      want = mode_decode(st_q.clkmd);
      lv = {external_crystal_osc, low_rc_osc, high_rc_osc};
      rise = lv & ~st_q.osc_prev;
      st_d.osc_prev = lv;
      idx = haddr[7:2];
      addr_ok = hsel && htrans[1] && hready;
      target = st_q.fast ? scsb_pkg::BOOT_FAST_CYC : scsb_pkg::BOOT_NORM_CYC;
      st_d.ready = 1'b1;
      st_d.resp = 1'b0;
      st_d.rst_vec = scsb_pkg::RESET_ADDR;
      st_d.irq_vec = scsb_pkg::IRQ_ADDR;

      // Data phase of a write; only mapped registers store.
      if (st_q.wr_pend) begin
         case (st_q.wr_idx)
            scsb_pkg::IDX_CLKMD: st_d.clkmd = hwdata[7:0];
            scsb_pkg::IDX_XOSC: st_d.xosc = hwdata[7:0];
            scsb_pkg::IDX_TRIM: st_d.trim = hwdata[7:0];
            default: st_d.wr_pend = 1'b0;
         endcase
      end

      // Address phase; reads answer in the next cycle with no wait.
      st_d.wr_pend = addr_ok && hwrite;
      st_d.wr_idx = idx;
      if (addr_ok && !hwrite) begin
         case (idx)
            scsb_pkg::IDX_CLKMD: st_d.rdata = {24'h0, st_d.clkmd};
            scsb_pkg::IDX_XOSC: st_d.rdata = {24'h0, st_d.xosc};
            scsb_pkg::IDX_TRIM: st_d.rdata = {24'h0, st_d.trim};
            scsb_pkg::IDX_STAT: st_d.rdata = {24'h0, st_q.sysclk, st_q.act_k,
               st_q.act_src, st_q.wdt_en, st_q.core_rst_n};
            default: st_d.rdata = 32'h0;
         endcase
      end

      // Boot sequence: straps caught one edge after release, then the
      // low RC edges are counted while the core stays in reset.
      case (st_q.state)
         scsb_pkg::ST_BOOT: begin
            if (!st_q.straps_taken) begin
               st_d.straps_taken = 1'b1;
               st_d.fast = boot_fast;
               st_d.cal = cal_option;
               st_d.cnt = 12'h0;
            end else if (rise[1]) begin
               st_d.cnt = st_q.cnt + 12'h1;
               if (st_d.cnt == target) begin
                  st_d.state = scsb_pkg::ST_RUN;
                  st_d.core_rst_n = 1'b1;
                  st_d.wdt_en = 1'b0;
                  case (st_q.cal)
                     scsb_pkg::CAL_DIV2: st_d.clkmd = scsb_pkg::MD_HRC_DIV2;
                     scsb_pkg::CAL_DIV4: st_d.clkmd = scsb_pkg::MD_HRC_DIV4;
                     scsb_pkg::CAL_DIV8: st_d.clkmd = scsb_pkg::MD_HRC_DIV8;
                     scsb_pkg::CAL_DIV16: st_d.clkmd = scsb_pkg::MD_HRC_DIV16;
                     scsb_pkg::CAL_DIV32: st_d.clkmd = scsb_pkg::MD_HRC_DIV32;
                     scsb_pkg::CAL_LRC: st_d.clkmd = scsb_pkg::MD_LRC;
                     default: begin
                        // Uncalibrated: fast boot sets high RC /64, normal boot the reset mode.
                        st_d.wdt_en = 1'b1;
                        st_d.clkmd = st_q.fast ? scsb_pkg::MD_HRC_DIV64
                           : scsb_pkg::MD_RESET;
                     end
                  endcase
               end
            end
         end
         scsb_pkg::ST_RUN: st_d.core_rst_n = 1'b1;
         default: st_d.state = scsb_pkg::ST_BOOT;
      endcase

      // Clock switch. A new selection is taken only while the output is
      // low, and a /1 source only while it is low too, so no phase is cut.
      if (want != {st_q.act_src, st_q.act_k} && !st_q.sysclk
          && (want[2:0] != 3'h0 || !osc_pick(lv, want[4:3]))) begin
         st_d.act_src = want[4:3];
         st_d.act_k = want[2:0];
         st_d.div_cnt = 6'h0;
         st_d.sysclk = 1'b0;
      end else begin
         if (osc_pick(rise, st_q.act_src)) begin
            st_d.div_cnt = st_q.div_cnt + 6'h1;
         end
         if (st_q.act_k == 3'h0) begin
            st_d.sysclk = osc_pick(lv, st_q.act_src);
         end else begin
            st_d.sysclk = st_d.div_cnt[st_q.act_k - 3'h1];
         end
      end
   end

   // Register stage; reset takes constants only.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
         st_q.clkmd <= scsb_pkg::MD_RESET;
         st_q.trim <= scsb_pkg::TRIM_RESET;
         st_q.ready <= 1'b1;
         st_q.state <= scsb_pkg::ST_BOOT;
         st_q.act_src <= scsb_pkg::SRC_LRC;
         st_q.wdt_en <= 1'b1;
         st_q.rst_vec <= scsb_pkg::RESET_ADDR;
         st_q.irq_vec <= scsb_pkg::IRQ_ADDR;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Enables follow their bits directly; no interlock stops software
   // from disabling the running source.
   assign high_rc_osc_en = st_q.clkmd[scsb_pkg::HRC_EN_BIT];
   assign low_rc_osc_en = st_q.clkmd[scsb_pkg::LRC_EN_BIT];
   assign external_crystal_osc_en = st_q.xosc[scsb_pkg::XO_EN_BIT];
   assign external_crystal_osc_drive = st_q.xosc[scsb_pkg::XO_DRV_HI:scsb_pkg::XO_DRV_LO];
   assign high_rc_osc_trim = st_q.trim;
   assign sys_clk = st_q.sysclk;
   assign core_reset_n = st_q.core_rst_n;
   assign reset_vector = st_q.rst_vec;
   assign irq_vector = st_q.irq_vec;
   assign watchdog_en = st_q.wdt_en;
   assign hreadyout = st_q.ready;
   assign hresp = st_q.resp;
   assign hrdata = st_q.rdata;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   boot_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_q.core_rst_n) |-> $past(st_q.cnt) == ($past(st_q.fast)
         ? scsb_pkg::BOOT_FAST_CYC - 12'h1 : scsb_pkg::BOOT_NORM_CYC - 12'h1))
      else $error("boot delay length wrong");
   vectors_a: assert property (@(posedge hclk) disable iff (!hresetn)
      core_reset_n |-> reset_vector == scsb_pkg::RESET_ADDR
         && irq_vector == scsb_pkg::IRQ_ADDR)
      else $error("start or interrupt address wrong");
   lrc_boot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(core_reset_n) && st_q.cal == scsb_pkg::CAL_LRC
         |-> !high_rc_osc_en && st_q.clkmd == scsb_pkg::MD_LRC)
      else $error("low RC boot left high RC on");
   cal_boot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(core_reset_n) && st_q.cal != scsb_pkg::CAL_OFF && st_q.cal <= scsb_pkg::CAL_LRC
         |-> !watchdog_en && low_rc_osc_en)
      else $error("calibrated boot state wrong");
   nocal_boot_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(core_reset_n)
         && (st_q.cal == scsb_pkg::CAL_OFF || st_q.cal > scsb_pkg::CAL_LRC)
         |-> watchdog_en)
      else $error("uncalibrated boot kept watchdog off");
   mode_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q.wr_pend && st_q.wr_idx == scsb_pkg::IDX_CLKMD && st_q.state == scsb_pkg::ST_RUN
         |=> st_q.clkmd == $past(hwdata[7:0]))
      else $error("mode write lost");
   switch_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed({st_q.act_src, st_q.act_k}) |-> !$past(st_q.sysclk) && !st_q.sysclk)
      else $error("clock switched during high phase");
   div_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(st_q.sysclk) && st_q.act_k != 3'h0 |-> st_q.div_cnt != $past(st_q.div_cnt))
      else $error("divided clock rose without a source edge");
   drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_q.wr_pend && st_q.wr_idx == scsb_pkg::IDX_XOSC
         |=> external_crystal_osc_drive == $past(hwdata[6:5]))
      else $error("crystal drive field not stored");
endmodule : scsb_top

/* File: tb/scsb_osc_model.sv */
/*
 * Behavioural model of the three oscillators that feed the clock select
 * block: each runs while its enable is high and sits low while stopped.
 * Assumes enables come from the design and levels are read on hclk.
 */
`timescale 1ns/100ps
module scsb_osc_model #(
   parameter int HRC_HALF = 3,
   parameter int LRC_HALF = 4,
   parameter int XO_HALF = 5
) (
   // Clock.
   input wire logic hclk,
   // Enables from the design.
   input wire logic hrc_en,
   input wire logic lrc_en,
   input wire logic xo_en,
   // Oscillator levels.
   output logic hrc,
   output logic lrc,
   output logic xo
);
   localparam int HALF [3] = '{HRC_HALF, LRC_HALF, XO_HALF};
   int cnt [3] = '{0, 0, 0};
   logic [2:0] lvl = 3'h0;
   logic [2:0] en;
   assign en = {xo_en, lrc_en, hrc_en};
   assign {xo, lrc, hrc} = lvl;
   // A stopped oscillator gives no edges at all, so a design that switches
   // onto it before enabling it sees its clock freeze low.
   always @(posedge hclk) begin
      for (int i = 0; i < 3; i++) begin
         if (!en[i]) begin
            lvl[i] <= 1'b0;
            cnt[i] <= 0;
         end else if (cnt[i] == HALF[i] - 1) begin
            lvl[i] <= ~lvl[i];
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule : scsb_osc_model

/* File: tb/test_system_clock_select_boot.sv */
/*
 * Self-checking bench for the clock select and boot block: boots fast under every
 * calibration strap and normal with code 0, checks trim and crystal fields, then walks all clock modes.
 * Assumes the oscillator model beside it and one AHB-Lite slave on the bus.
 */
`timescale 1ns/100ps
module test_system_clock_select_boot;
   localparam logic [7:0] MODES [8] = '{8'hf4, 8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'h74, 8'hb4};
   localparam int DIVS [8] = '{1, 2, 4, 8, 16, 32, 64, 1};
   localparam int SRCS [8] = '{1, 0, 0, 0, 0, 0, 0, 2};
   localparam int LOG2 [8] = '{0, 1, 2, 3, 4, 5, 6, 0};
   localparam logic [7:0] CAL_MD [7] = '{8'he4, 8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic boot_fast = 1'b1;
   logic [2:0] cal_option = 3'h0;
   logic hready, hresp, hrc, lrc, xo, hrc_en, lrc_en, xo_en, sys_clk, core_reset_n, wdt_en;
   logic [31:0] hrdata, rd;
   logic [1:0] xo_drv;
   logic [7:0] trim;
   logic [10:0] rst_vec, irq_vec;
   logic [2:0] osc_v;
   logic lrc_q = 1'b0;
   logic rst_q = 1'b0;
   logic sys_q = 1'b0;
   logic ph_ok = 1'b0;
   int ph = 0;
   int lrc_rises = 0;
   int num_errors = 0;
   int tests_run = 0;
   assign osc_v = {xo, lrc, hrc};
   // The bus slave's ready is fed straight back as the bus ready.
   scsb_top i_scsb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .high_rc_osc(hrc),
      .low_rc_osc(lrc), .external_crystal_osc(xo), .boot_fast(boot_fast),
      .cal_option(cal_option), .high_rc_osc_en(hrc_en), .low_rc_osc_en(lrc_en),
      .external_crystal_osc_en(xo_en), .external_crystal_osc_drive(xo_drv),
      .high_rc_osc_trim(trim), .sys_clk(sys_clk), .core_reset_n(core_reset_n),
      .reset_vector(rst_vec), .irq_vector(irq_vec), .watchdog_en(wdt_en));
   scsb_osc_model i_scsb_osc_model (.hclk(hclk), .hrc_en(hrc_en), .lrc_en(lrc_en),
      .xo_en(xo_en), .hrc(hrc), .lrc(lrc), .xo(xo));
   // Free-running bus clock.
   always #2.5 hclk = ~hclk;
   // ----------------------------------------------------------------
   // Checking and bus tasks.
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic give_up(input logic ok);
      if (!ok) begin
         check(32'h0, 32'h1);
         stop_test();
      end
   endtask : give_up
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      give_up(hready === 1'b1);
   endtask : wait_ready
   // One single word transfer; read data lands in rd.
   task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, idx, 2'b00};
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask : ahb
   // Counts low RC rises after the strap edge, and times each sys_clk phase.
   // No mode here gives a sys_clk phase under four cycles, so a shorter one is a glitch.
   always @(posedge hclk) begin
      lrc_q <= lrc;
      rst_q <= hresetn;
      sys_q <= sys_clk;
      ph <= (sys_clk !== sys_q) ? 1 : ph + 1;
      if (!hresetn) begin
         lrc_rises <= 0;
      end else if (rst_q && !lrc_q && lrc && !core_reset_n) begin
         lrc_rises <= lrc_rises + 1;
      end
      if (!core_reset_n) begin
         ph_ok <= 1'b0;
      end else if (sys_clk !== sys_q) begin
         if (ph_ok) begin
            check(32'(ph >= 4), 32'h1);
         end
         ph_ok <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic boot(input logic fast, input logic [2:0] cal);
      int n;
      logic nocal;
      logic [7:0] md;
      // Codes above the low RC option are left uncalibrated, as code 0 is.
      nocal = (cal == 3'h0) || (cal == 3'h7);
      md = nocal ? (fast ? 8'h74 : 8'he4) : CAL_MD[cal];
      @(posedge hclk);
      hresetn <= 1'b0;
      boot_fast <= fast;
      cal_option <= cal;
      repeat (8) @(posedge hclk);
      check({trim, xo_drv, xo_en, lrc_en, hrc_en, wdt_en, core_reset_n, hresp},
            {8'h80, 2'h0, 5'b01010, 1'b0});
      check({rst_vec, irq_vec}, {11'h001, 11'h010});
      hresetn <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
      end while (core_reset_n !== 1'b1 && n < 30000);
      give_up(core_reset_n === 1'b1);
      check(lrc_rises, fast ? 45 : 3000);
      check({wdt_en, lrc_en, hrc_en}, {nocal, 1'b1, md[4]});
      ahb(1'b0, scsb_pkg::IDX_CLKMD, 32'h0);
      check(rd, {24'h0, md});
   endtask : boot
   // Old source stays enabled in every write, as software must ensure.
   task automatic switch_mode(input int k);
      int s, r, d;
      logic p;
      s = 0;
      r = 0;
      p = 1'b0;
      ahb(1'b1, scsb_pkg::IDX_CLKMD, {24'h0, MODES[k]});
      ahb(1'b0, scsb_pkg::IDX_CLKMD, 32'h0);
      check(rd, {24'h0, MODES[k]});
      check({hrc_en, lrc_en}, {MODES[k][4], MODES[k][2]});
      repeat (400) @(posedge hclk);
      for (int i = 0; i < 3000; i++) begin
         @(posedge hclk);
         s += (sys_clk && !sys_q);
         r += (osc_v[SRCS[k]] && !p);
         p = osc_v[SRCS[k]];
      end
      d = r - s * DIVS[k];
      check(32'(d <= DIVS[k] + 1 && d >= -DIVS[k] - 1), 32'h1);
      // Bit 7 is the live clock level at the read, so it is masked; the last
      // boot is uncalibrated, so the watchdog stays on.
      ahb(1'b0, scsb_pkg::IDX_STAT, 32'h0);
      check(rd & 32'hffffff7f, {25'h0, 3'(LOG2[k]), 2'(SRCS[k]), 2'b11});
   endtask : switch_mode
   // Main sequence.
   initial begin
      logic [7:0] v;
      void'($urandom(32'hddd8cd54));
      boot(1'b0, 3'h0);
      for (int c = 0; c < 8; c++) begin
         boot(1'b1, 3'(c));
      end
      repeat (4) begin
         v = 8'($urandom);
         ahb(1'b1, scsb_pkg::IDX_TRIM, {24'h0, v});
         ahb(1'b1, 6'(16 + $urandom_range(47)), 32'hffffffff);
         ahb(1'b0, scsb_pkg::IDX_TRIM, 32'h0);
         check(rd, {24'h0, v});
         check(trim, v);
         ahb(1'b0, 6'(16 + $urandom_range(47)), 32'h0);
         check(rd, 32'h0);
      end
      for (int c = 1; c < 4; c++) begin
         ahb(1'b1, scsb_pkg::IDX_XOSC, {24'h0, 1'b1, 2'(c), 5'h0});
         ahb(1'b0, scsb_pkg::IDX_XOSC, 32'h0);
         check(rd, {24'h0, 1'b1, 2'(c), 5'h0});
         check({xo_en, xo_drv}, {1'b1, 2'(c)});
      end
      for (int k = 0; k < 8; k++) begin
         switch_mode(k);
      end
      stop_test();
   end
endmodule : test_system_clock_select_boot
